// file: rtl/sysc_pkg.sv
// Purpose: shared constants and types for the system configuration block
// Assumes: 32-bit avalon-mm data, word-aligned byte addresses
// Notes:   field positions, reset values and counts live here only
package sysc_pkg;

   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [3:0]  SYSC_OFS_MEM_WAIT  = 4'h0;
   localparam logic [3:0]  SYSC_OFS_PERIPH    = 4'h4;
   localparam logic [3:0]  SYSC_OFS_STATUS    = 4'h8;

   // ******************************************************************
   // reset values and writable masks
   // ******************************************************************
   localparam logic [15:0] SYSC_MEM_RESET     = 16'h0000;
   localparam logic [15:0] SYSC_MEM_MASK      = 16'h00e7;
   localparam logic [15:0] SYSC_PER_RESET     = 16'h0008;
   localparam logic [15:0] SYSC_PER_MASK      = 16'h1fff;

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int SYSC_ROM_LSB   = 5;
   localparam int SYSC_RAM_LSB   = 0;
   localparam int SYSC_S2_RATE   = 12;
   localparam int SYSC_S1_RATE   = 11;
   localparam int SYSC_T2_SEL    = 10;
   localparam int SYSC_PRE_LSB   = 8;
   localparam int SYSC_NEST      = 7;
   localparam int SYSC_BTO_EN    = 6;
   localparam int SYSC_S1_PIN    = 5;
   localparam int SYSC_T0_PRE    = 4;
   localparam int SYSC_T0_EDGE   = 2;
   localparam int SYSC_T1_PRE    = 1;
   localparam int SYSC_T1_PIN    = 0;

   // ******************************************************************
   // wait-state codes, in half internal cycles
   // ******************************************************************
   localparam logic [2:0]  SYSC_WAIT_CODE8    = 3'h0;
   localparam logic [2:0]  SYSC_WAIT_CODE4    = 3'h1;
   localparam logic [2:0]  SYSC_WAIT_CODE2    = 3'h2;
   localparam logic [3:0]  SYSC_WAIT_N8       = 4'h8;
   localparam logic [3:0]  SYSC_WAIT_N4       = 4'h4;
   localparam logic [3:0]  SYSC_WAIT_N2       = 4'h2;
   localparam logic [3:0]  SYSC_WAIT_N0       = 4'h0;
   localparam logic [2:0]  SYSC_HALF_PER_CYC  = 3'h2;

   // ******************************************************************
   // prescaler: divisor in half steps (3.0, 2.5, 2.0, 1.5 doubled)
   // ******************************************************************
   localparam logic [2:0]  SYSC_DIV2_X00      = 3'h6;
   localparam logic [2:0]  SYSC_DIV2_X01      = 3'h5;
   localparam logic [2:0]  SYSC_DIV2_X10      = 3'h4;
   localparam logic [2:0]  SYSC_DIV2_X11      = 3'h3;

   // ******************************************************************
   // bus-timeout watchdog: 128 x 16 internal cycles
   // ******************************************************************
   localparam int          SYSC_BTO_BASE      = 128;
   localparam int          SYSC_BTO_MULT      = 16;
   localparam logic [11:0] SYSC_BTO_CYCLES    =
      12'(SYSC_BTO_BASE * SYSC_BTO_MULT);
   localparam logic [2:0]  SYSC_NEST_LOCK     = 3'h7;

   // timer 0 edge select codes
   typedef enum logic [1:0] {
      SYSC_EDGE_OFF  = 2'h0,
      SYSC_EDGE_RISE = 2'h1,
      SYSC_EDGE_FALL = 2'h2,
      SYSC_EDGE_ANY  = 2'h3
   } sysc_edge_t;

   // decoded configuration bundle handed to the rest of the chip
   typedef struct packed {
      logic       serial2_rate_range;
      logic       serial1_rate_range;
      logic       timer_two_clock_select;
      logic [2:0] base_div_half;
      logic       nesting_allow;
      logic       bus_timeout_enable;
      logic       serial1_pin_select;
      logic       timer_zero_prescale_en;
      sysc_edge_t timer_zero_edge;
      logic       timer_one_prescale_en;
      logic       timer_one_input_select;
   } sysc_periph_t;

   // wait-state decode for the memory side
   typedef struct packed {
      logic [3:0] rom_waits;
      logic [3:0] ram_waits;
   } sysc_wait_t;

endpackage

// file: rtl/sysc_regs.sv
// Purpose: system configuration registers with avalon-mm slave
// Assumes: single clock domain, synchronous active-low reset
// Notes:   drives decoded controls, wait stretching and bus timeout
`timescale 1ns/1ns

// Functional notes
// - rom access-time field sits in bits 7..5, reset to zero
// - ram access-time field sits in bits 2..0, reset to zero
// - codes 000,001,010,011 give 8,4,2,0 wait states
// - wait states count half clocks; two states stretch one clock
// - memory register bits 15..8 and 4..3 do nothing
// - peripheral register bits 15..13 do nothing
// - bit 12 picks serial channel two rate range, 1 means low
// - bit 11 picks serial channel one rate range, 1 means low
// - bit 10 picks timer two clock: xtal/2 or base clock/4
// - bits 9..8 select the base clock prescaler divisor
// - divisor codes 00..11 give 3.0, 2.5, 2.0, 1.5
// - bit 7 low forces level 7 on entry, high allows nesting
// - bit 6 enables the bus-timeout watchdog
// - enabled watchdog flags bus error after 128x16 clocks unacked
// - bit 5 gives port pins 7 and 6 to serial channel one
// - bit 4 selects timer zero prescaler, xtal/2 or xtal/32
// - bits 3..2 select timer zero input edge
// - edge codes: off, rising, falling (reset), any
// - bit 1 selects timer one prescaler, xtal/2 or xtal/32
// - bit 0 routes port bit 5 to timer one input
// - reset clears peripheral register except upper edge bit
module sysc_regs
   import sysc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   input  wire logic        mem_start,
   input  wire logic        mem_is_rom,
   output logic             mem_busy,
   output logic             mem_done,
   input  wire logic        cyc_active,
   input  wire logic        cyc_ack,
   output logic             bus_error,
   input  wire logic [2:0]  irq_level,
   output logic [2:0]       entry_level,
   output sysc_periph_t     periph_cfg,
   output sysc_wait_t       wait_cfg,
   output logic [1:0]       t2_clk_sel
);

   // ******************************************************************
   // storage
   // ******************************************************************
   logic [15:0]  mem_wait_config_reg;
   logic [15:0]  periph_sys_config_reg;
   logic [31:0]  rdata_reg;
   logic         wait_reg;
   logic [1:0]   resp_reg;
   logic [11:0]  bto_count_reg;
   logic         bus_error_reg;
   logic         bto_seen_reg;
   logic [2:0]   entry_level_reg;
   sysc_periph_t periph_cfg_reg;
   sysc_wait_t   wait_cfg_reg;
   logic [1:0]   t2_clk_sel_reg;
   logic [3:0]   sel_waits;
   logic         req;
   logic         hit_mem;
   logic         hit_per;
   logic         hit_sts;
   logic [15:0]  wdata16;
   logic [15:0]  lane_mask;

   // ******************************************************************
   // bus decode
   // ******************************************************************
   // one wait cycle per access: answer on the edge after request
   assign req      = (avs_read || avs_write) && wait_reg;
   assign hit_mem  = avs_address == SYSC_OFS_MEM_WAIT;
   assign hit_per  = avs_address == SYSC_OFS_PERIPH;
   assign hit_sts  = avs_address == SYSC_OFS_STATUS;
   assign wdata16  = avs_writedata[15:0];
   assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // handshake: waitrequest is its own flop, low one cycle per access
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wait_reg <= 1'b1;
         resp_reg <= 2'h0;
      end else begin
         wait_reg <= !req;
         if (req) begin
            // unmapped addresses answer with slave error
            resp_reg <= (hit_mem || hit_per || hit_sts) ? 2'h0 : 2'h2;
         end
      end
   end

   // ******************************************************************
   // configuration registers
   // ******************************************************************
   // memory timing: only rom and ram fields hold state
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mem_wait_config_reg <= SYSC_MEM_RESET;
      end else if (req && avs_write && hit_mem) begin
         mem_wait_config_reg <= (mem_wait_config_reg & ~lane_mask)
            | (wdata16 & lane_mask & SYSC_MEM_MASK);
      end
   end

   // peripheral system: timer zero upper edge bit resets to one
   always_ff @(posedge clock) begin
      if (!resetn) begin
         periph_sys_config_reg <= SYSC_PER_RESET;
      end else if (req && avs_write && hit_per) begin
         periph_sys_config_reg <= (periph_sys_config_reg & ~lane_mask)
            | (wdata16 & lane_mask & SYSC_PER_MASK);
      end
   end

   // read mux; status word shows watchdog and stretch state
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req && avs_read) begin
         if (hit_mem) begin
            rdata_reg <= {16'h0000, mem_wait_config_reg};
         end else if (hit_per) begin
            rdata_reg <= {16'h0000, periph_sys_config_reg};
         end else if (hit_sts) begin
            rdata_reg <= {29'h0, mem_busy, bto_seen_reg, bus_error_reg};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // ******************************************************************
   // decoded controls
   // ******************************************************************
   // wait-state decode; reserved codes fall back to the slowest
   // setting, which is safe if software ignores the reserved rule
   function automatic logic [3:0] sysc_dec_wait(input logic [2:0] c);
      logic [3:0] n;
      n = SYSC_WAIT_N0;
      if (c == SYSC_WAIT_CODE8) begin
         n = SYSC_WAIT_N8;
      end else if (c == SYSC_WAIT_CODE4) begin
         n = SYSC_WAIT_N4;
      end else if (c == SYSC_WAIT_CODE2) begin
         n = SYSC_WAIT_N2;
      end else if (c != 3'h3) begin
         n = SYSC_WAIT_N8;
      end
      return n;
   endfunction

   // prescaler divisor expressed in half steps of the internal clock
   function automatic logic [2:0] sysc_dec_div(input logic [1:0] s);
      logic [2:0] d;
      d = SYSC_DIV2_X00;
      unique case (s)
         2'h0: begin
            d = SYSC_DIV2_X00;
         end
         2'h1: begin
            d = SYSC_DIV2_X01;
         end
         2'h2: begin
            d = SYSC_DIV2_X10;
         end
         2'h3: begin
            d = SYSC_DIV2_X11;
         end
      endcase
      return d;
   endfunction

   // register the decode so every output is a flip-flop
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wait_cfg_reg <= '{rom_waits: SYSC_WAIT_N8, ram_waits: SYSC_WAIT_N8};
      end else begin
         wait_cfg_reg.rom_waits <= sysc_dec_wait(
            mem_wait_config_reg[SYSC_ROM_LSB +: 3]);
         wait_cfg_reg.ram_waits <= sysc_dec_wait(
            mem_wait_config_reg[SYSC_RAM_LSB +: 3]);
      end
   end

   // peripheral controls fan out to serial, timer and port blocks
   always_ff @(posedge clock) begin
      if (!resetn) begin
         periph_cfg_reg <= '0;
         periph_cfg_reg.timer_zero_edge <= SYSC_EDGE_FALL;
         periph_cfg_reg.base_div_half   <= SYSC_DIV2_X00;
      end else begin
         periph_cfg_reg.serial2_rate_range <=
            periph_sys_config_reg[SYSC_S2_RATE];
         periph_cfg_reg.serial1_rate_range <=
            periph_sys_config_reg[SYSC_S1_RATE];
         periph_cfg_reg.timer_two_clock_select <=
            periph_sys_config_reg[SYSC_T2_SEL];
         periph_cfg_reg.base_div_half <= sysc_dec_div(
            periph_sys_config_reg[SYSC_PRE_LSB +: 2]);
         periph_cfg_reg.nesting_allow <=
            periph_sys_config_reg[SYSC_NEST];
         periph_cfg_reg.bus_timeout_enable <=
            periph_sys_config_reg[SYSC_BTO_EN];
         periph_cfg_reg.serial1_pin_select <=
            periph_sys_config_reg[SYSC_S1_PIN];
         periph_cfg_reg.timer_zero_prescale_en <=
            periph_sys_config_reg[SYSC_T0_PRE];
         periph_cfg_reg.timer_zero_edge <= sysc_edge_t'(
            periph_sys_config_reg[SYSC_T0_EDGE +: 2]);
         periph_cfg_reg.timer_one_prescale_en <=
            periph_sys_config_reg[SYSC_T1_PRE];
         periph_cfg_reg.timer_one_input_select <=
            periph_sys_config_reg[SYSC_T1_PIN];
      end
   end

   // timer two source one-hot: bit0 xtal/2, bit1 base clock/4
   always_ff @(posedge clock) begin
      if (!resetn) begin
         t2_clk_sel_reg <= 2'h1;
      end else begin
         t2_clk_sel_reg <= periph_sys_config_reg[SYSC_T2_SEL]
            ? 2'h2 : 2'h1;
      end
   end

   // level placed in the status register on interrupt entry
   always_ff @(posedge clock) begin
      if (!resetn) begin
         entry_level_reg <= SYSC_NEST_LOCK;
      end else begin
         entry_level_reg <= periph_sys_config_reg[SYSC_NEST]
            ? irq_level : SYSC_NEST_LOCK;
      end
   end

   // ******************************************************************
   // bus-timeout watchdog
   // ******************************************************************
   // counts clocks of an unacknowledged cycle; error is a level that
   // holds until the cycle ends, sticky seen bit cleared by status read
   always_ff @(posedge clock) begin
      if (!resetn) begin
         bto_count_reg <= 12'h000;
         bus_error_reg <= 1'b0;
      end else if (!periph_sys_config_reg[SYSC_BTO_EN] || !cyc_active
                   || cyc_ack) begin
         bto_count_reg <= 12'h000;
         bus_error_reg <= 1'b0;
      end else if (bto_count_reg == SYSC_BTO_CYCLES - 12'h1) begin
         bus_error_reg <= 1'b1;
      end else begin
         bto_count_reg <= bto_count_reg + 12'h1;
      end
   end

   // sticky record; a new error in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         bto_seen_reg <= 1'b0;
      end else if (bus_error_reg) begin
         bto_seen_reg <= 1'b1;
      end else if (req && avs_read && hit_sts) begin
         bto_seen_reg <= 1'b0;
      end
   end

   // ******************************************************************
   // wait-state stretcher
   // ******************************************************************
   assign sel_waits = mem_is_rom ? wait_cfg_reg.rom_waits
                                 : wait_cfg_reg.ram_waits;

   sysc_wait_stretch sysc_wait_stretch_inst (
      .clock    (clock),
      .resetn   (resetn),
      .start    (mem_start),
      .waits    (sel_waits),
      .busy_reg (mem_busy),
      .done_reg (mem_done)
   );

   // ******************************************************************
   // outputs
   // ******************************************************************
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign avs_response    = resp_reg;
   assign bus_error       = bus_error_reg;
   assign entry_level     = entry_level_reg;
   assign periph_cfg      = periph_cfg_reg;
   assign wait_cfg        = wait_cfg_reg;
   assign t2_clk_sel      = t2_clk_sel_reg;

endmodule

// file: rtl/sysc_wait_stretch.sv
// Purpose: stretch one memory access by the programmed wait states
// Assumes: start is a one-cycle pulse, waits is in half internal cycles
// Notes:   two wait states make one clock of stretch
`timescale 1ns/1ns
module sysc_wait_stretch
   import sysc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [3:0] waits,
   output logic            busy_reg,
   output logic            done_reg
);

   logic [2:0] left_reg;

   // count down whole clocks; an odd half state is not reachable
   always_ff @(posedge clock) begin
      if (!resetn) begin
         left_reg <= 3'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start && !busy_reg) begin
            if (waits == SYSC_WAIT_N0) begin
               done_reg <= 1'b1;
            end else begin
               left_reg <= 3'(waits / 4'(SYSC_HALF_PER_CYC));
               busy_reg <= 1'b1;
            end
         end else if (busy_reg) begin
            if (left_reg == 3'h1) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            left_reg <= left_reg - 3'h1;
         end
      end
   end

endmodule

// file: tb/sysc_regs_monitor.sv
// Purpose: protocol and decode checks on the config registers
// Assumes: sees only the ports of sysc_regs, one clock domain
// Notes:   watchdog bound allows one cycle of decode lag
`timescale 1ns/1ns
module sysc_regs_monitor
   import sysc_pkg::*;
(
   input wire logic         clock,
   input wire logic         resetn,
   input wire logic [3:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [31:0]  avs_readdata,
   input wire logic         avs_waitrequest,
   input wire logic [1:0]   avs_response,
   input wire logic         mem_start,
   input wire logic         mem_is_rom,
   input wire logic         mem_busy,
   input wire logic         mem_done,
   input wire logic         cyc_active,
   input wire logic         cyc_ack,
   input wire logic         bus_error,
   input wire logic [2:0]   irq_level,
   input wire logic [2:0]   entry_level,
   input wire sysc_periph_t periph_cfg,
   input wire sysc_wait_t   wait_cfg,
   input wire logic [1:0]   t2_clk_sel
);
   // ****************************************************************
   // helper counters
   // ****************************************************************
   logic [2:0]  str_reg;
   logic [11:0] hang_reg;
   logic [3:0]  sel_waits;
   logic        rd_ack;

   assign sel_waits = mem_is_rom ? wait_cfg.rom_waits : wait_cfg.ram_waits;
   assign rd_ack    = avs_read && !avs_waitrequest;

   // cycles left in a stretch; done is due when it reaches one
   always_ff @(posedge clock) begin
      if (!resetn) str_reg <= 3'h0;
      else if (mem_start && !mem_busy && str_reg <= 3'h1)
         str_reg <= 3'(sel_waits >> 1) + 3'h1;
      else if (str_reg != 3'h0) str_reg <= str_reg - 3'h1;
   end

   // unacknowledged cycle length, saturating so it never wraps
   always_ff @(posedge clock) begin
      if (!resetn || !(periph_cfg.bus_timeout_enable && cyc_active
                       && !cyc_ack)) hang_reg <= 12'h000;
      else if (hang_reg != 12'hfff) hang_reg <= hang_reg + 12'h001;
   end

   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   a_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop after a request");
   a_wait_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest stayed low");
   a_unmapped_err: assert property (
      (avs_read || avs_write) && avs_waitrequest && avs_address > 4'h8
      |=> avs_response == 2'h2) else $error("no error on unmapped");
   a_mem_unused: assert property (
      rd_ack && avs_address == 4'h0 |-> (avs_readdata & ~32'he7) == 32'h0)
      else $error("unused memory timing bits read nonzero");
   a_cfg_readback: assert property (
      rd_ack && avs_address == 4'h4 |-> {periph_cfg[13:11],
      periph_cfg[7:0]} == {avs_readdata[12:10], avs_readdata[7:0]})
      else $error("decoded controls differ from register");
   a_prescale_div: assert property (
      rd_ack && avs_address == 4'h4 |-> periph_cfg.base_div_half
      == 3'h6 - {1'b0, avs_readdata[9:8]}) else $error("bad divisor");
   a_t2_onehot: assert property (
      t2_clk_sel == {periph_cfg.timer_two_clock_select,
      !periph_cfg.timer_two_clock_select}) else $error("bad t2 select");
   a_entry_lock: assert property (
      !periph_cfg.nesting_allow && !$past(periph_cfg.nesting_allow)
      |-> entry_level == 3'h7) else $error("entry level not 7");
   a_entry_nest: assert property (
      periph_cfg.nesting_allow && $past(periph_cfg.nesting_allow) &&
      $stable(irq_level) |-> entry_level == irq_level)
      else $error("entry level not serviced level");
   a_done_timing: assert property (
      mem_done == (str_reg == 3'h1)) else $error("stretch length wrong");
   a_busy_span: assert property (
      mem_busy == (str_reg > 3'h1)) else $error("busy span wrong");
   a_bto_rise: assert property (
      $rose(bus_error) |-> hang_reg inside {[12'd2047:12'd2049]})
      else $error("bus error raised at wrong count");
   a_bto_late: assert property (
      hang_reg == 12'd2051 |-> bus_error) else $error("bus error missing");
   a_bto_clear: assert property (
      bus_error && cyc_ack |=> !bus_error) else $error("bus error held");

   c_stretch: cover property (mem_done && mem_is_rom);
   c_timeout: cover property ($rose(bus_error));
   c_refused: cover property (avs_response == 2'h2);
endmodule

// file: tb/sysc_regs_tb.sv
// Purpose: directed bench for the system configuration registers
// Assumes: the slave answers each request within the bench timeout
// Notes:   scenarios run in sequence after one reset
`timescale 1ns/1ns
module sysc_regs_tb
   import sysc_pkg::*;
;
   logic         clock           = 1'b0;
   logic         resetn          = 1'b0;
   logic [3:0]   avs_address     = 4'h0;
   logic         avs_read        = 1'b0;
   logic         avs_write       = 1'b0;
   logic [31:0]  avs_writedata   = 32'h0;
   logic [3:0]   avs_byteenable  = 4'h3;
   logic         mem_start       = 1'b0;
   logic         mem_is_rom      = 1'b0;
   logic         cyc_active      = 1'b0;
   logic         cyc_ack         = 1'b0;
   logic [2:0]   irq_level       = 3'h0;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic [1:0]   avs_response;
   logic         mem_busy;
   logic         mem_done;
   logic         bus_error;
   logic [2:0]   entry_level;
   sysc_periph_t periph_cfg;
   sysc_wait_t   wait_cfg;
   logic [1:0]   t2_clk_sel;
   logic [31:0]  rdv;
   logic [1:0]   rsp;
   int           fail_count      = 0;
   int           n_tests         = 0;
   int           cycles          = 0;

   sysc_regs sysc_regs_inst (
      .clock(clock), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .mem_start(mem_start),
      .mem_is_rom(mem_is_rom), .mem_busy(mem_busy), .mem_done(mem_done),
      .cyc_active(cyc_active), .cyc_ack(cyc_ack), .bus_error(bus_error),
      .irq_level(irq_level), .entry_level(entry_level),
      .periph_cfg(periph_cfg), .wait_cfg(wait_cfg),
      .t2_clk_sel(t2_clk_sel));

   // ****************************************************************
   // clock, timeout and shared tasks
   // ****************************************************************
   always #2 clock = ~clock;

   // a hang counts as a mismatch and ends the run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [15:0] d);
      @(posedge clock);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic finish_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      bus(1'b0, SYSC_OFS_MEM_WAIT, 16'h0);
      chk("mem reset", rdv, 32'h0);
      bus(1'b0, SYSC_OFS_PERIPH, 16'h0);
      chk("per reset", rdv, 32'h8);
      chk("rom reset", wait_cfg.rom_waits, 32'h8);
      chk("div reset", periph_cfg.base_div_half, 32'h6);
      chk("edge reset", periph_cfg.timer_zero_edge, 32'h2);
      chk("t2 reset", t2_clk_sel, 32'h1);
      chk("entry reset", entry_level, 32'h7);
   endtask

   // every defined code on both fields, then a timed access each
   task automatic t_mem();
      logic [3:0] wt [4] = '{4'h8, 4'h4, 4'h2, 4'h0};
      int n;
      bus(1'b1, SYSC_OFS_MEM_WAIT, 16'hff79);
      bus(1'b0, SYSC_OFS_MEM_WAIT, 16'h0);
      chk("mem unused", rdv, 32'h61);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, SYSC_OFS_MEM_WAIT, 16'((c << 5) | (3 - c)));
         @(posedge clock);
         chk("rom decode", wait_cfg.rom_waits, wt[c]);
         chk("ram decode", wait_cfg.ram_waits, wt[3-c]);
         for (int r = 0; r < 2; r++) begin
            mem_is_rom <= r[0];
            mem_start  <= 1'b1;
            @(posedge clock);
            mem_start <= 1'b0;
            n = 0;
            do begin
               @(posedge clock);
               n++;
            end while (mem_done !== 1'b1 && n < 20);
            chk("stretch", n, (r ? wt[c] : wt[3-c]) / 2 + 1);
         end
      end
   endtask

   task automatic t_per();
      logic [2:0] dv [4] = '{3'h6, 3'h5, 3'h4, 3'h3};
      irq_level <= 3'h5;
      bus(1'b1, SYSC_OFS_PERIPH, 16'hffff);
      bus(1'b0, SYSC_OFS_PERIPH, 16'h0);
      chk("per unused", rdv, 32'h1fff);
      chk("cfg ones", periph_cfg, 32'h3bff);
      chk("t2 base", t2_clk_sel, 32'h2);
      chk("entry nest", entry_level, 32'h5);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, SYSC_OFS_PERIPH, 16'((c << 8) | (c << 2)));
         repeat (2) @(posedge clock);
         chk("divisor", periph_cfg.base_div_half, dv[c]);
         chk("edge", periph_cfg.timer_zero_edge, c);
         chk("t2 xtal", t2_clk_sel, 32'h1);
         chk("entry lock", entry_level, 32'h7);
      end
      bus(1'b1, 4'hc, 16'h0000);
      chk("bad write", rsp, 32'h2);
      bus(1'b0, 4'hc, 16'h0);
      chk("bad read", rsp, 32'h2);
      chk("bad data", rdv, 32'h0);
      bus(1'b0, SYSC_OFS_PERIPH, 16'h0);
      chk("kept", rdv, 32'h30c);
   endtask

   // an unanswered cycle trips the watchdog only while enabled
   task automatic t_bto();
      int n;
      bus(1'b1, SYSC_OFS_PERIPH, 16'h0040);
      @(posedge clock);
      cyc_active <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (bus_error !== 1'b1 && n < 2100);
      chk("bto fire", n >= 2048 && n <= 2050, 32'h1);
      bus(1'b0, SYSC_OFS_STATUS, 16'h0);
      chk("status", rdv, 32'h3);
      cyc_ack <= 1'b1;
      repeat (2) @(posedge clock);
      chk("bto ack", bus_error, 32'h0);
      cyc_ack <= 1'b0;
      bus(1'b1, SYSC_OFS_PERIPH, 16'h0000);
      repeat (2100) @(posedge clock);
      chk("bto off", bus_error, 32'h0);
      cyc_active <= 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      t_reset();
      t_mem();
      t_per();
      t_bto();
      finish_test();
   end
endmodule

bind sysc_regs sysc_regs_monitor sysc_regs_monitor_inst (
   .clock(clock), .resetn(resetn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .mem_start(mem_start),
   .mem_is_rom(mem_is_rom), .mem_busy(mem_busy), .mem_done(mem_done),
   .cyc_active(cyc_active), .cyc_ack(cyc_ack), .bus_error(bus_error),
   .irq_level(irq_level), .entry_level(entry_level),
   .periph_cfg(periph_cfg), .wait_cfg(wait_cfg), .t2_clk_sel(t2_clk_sel));
